// file: verilog/vrs_sequencer.sv
// vrs_sequencer: code qualification, reference stepping, start-up and overvoltage
// assumes pin levels asynchronous, feedback as a 12-bit digitised word in 0.5 mV units
`timescale 1ns/10ps

// Behaviour
// RULE1: legacy/alternate modes sample code four times/cycle
// RULE2: non-ten modes qualify after 12 stable cycles
// RULE3: non-ten modes step every four switching cycles
// RULE4: ten-series mode samples six times per cycle
// RULE5: ten-series accepts after three equal readings
// RULE6: ten-series sets reference directly in one change
// RULE7: processor moves ten-series code one step
// RULE8: non-ten recognition may lag one period
// RULE9: fixed overvoltage threshold 1.65V or 1.95V
// RULE10: soft-start threshold max(fixed, reference plus 200mV)
// RULE11: after soft-start threshold is reference plus 200mV
// RULE12: low side held until hysteresis release, repeats
// RULE13: overvoltage never latches the controller off
// RULE14: below bias reset low drives high impedance
// RULE15: enable needs threshold input and both biases
// RULE16: all-ones code disables, other codes restart
// RULE17: all conditions met starts soft-start at once
// RULE18: wait 16 cycles, then 12.5mV per 16
// RULE19: feedback above ramp holds both switches off
// RULE20: each non-ten step is one table lsb
// RULE21: mode setting picks table, sampling and stepping
module vrs_sequencer #(
  parameter int unsigned SW_DIV = vrs_pkg::SW_DIV_CYCLES
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // register port
  input  wire vrs_pkg::vrs_bus_req_t busReq,
  output logic [31:0]               busRdData,
  // pins
  input  wire logic [4:0]           voltageCodeInputs,
  input  wire logic                 thresholdEnableInput,
  input  wire logic                 coreBiasOk,
  input  wire logic                 driverBiasSupplyOk,
  input  wire logic [11:0]          feedbackSense,
  // outputs
  output vrs_pkg::vrs_gate_t        lowSideGate,
  output logic [11:0]               referenceOut,
  output logic                      overvoltageTrip,
  output logic                      softStartActive
);
  import vrs_pkg::*;

  function automatic logic [11:0] codeToRef(input vrs_mode_t m, input logic [4:0] c);
    logic [11:0] base;
    logic [11:0] lsb;
    base = LEGACY_BASE;
    lsb  = LEGACY_LSB;
    case (m)
      VRS_MODE_TEN:
      begin
        base = TEN_BASE;
        lsb  = TEN_LSB;
      end
      VRS_MODE_ALT:
      begin
        base = ALT_BASE;
        lsb  = ALT_LSB;
      end
      default:
      begin
        base = LEGACY_BASE;
        lsb  = LEGACY_LSB;
      end
    endcase
    return 12'(base - 12'(lsb * 12'(c)));
  endfunction

  // synchronised pins
  logic [4:0]  codeS;
  logic [11:0] fbS;
  logic [2:0]  lvlS;
  vrs_sync #(.W(5)) uCodeSync (.sys_clk(sys_clk), .rst(rst), .asyncIn(voltageCodeInputs), .syncOut(codeS));
  vrs_sync #(.W(12)) uFbSync (.sys_clk(sys_clk), .rst(rst), .asyncIn(feedbackSense), .syncOut(fbS));
  vrs_sync #(.W(3)) uLvlSync (.sys_clk(sys_clk), .rst(rst),
    .asyncIn({thresholdEnableInput, coreBiasOk, driverBiasSupplyOk}), .syncOut(lvlS));

  // state
  vrs_mode_t   mode_r;
  vrs_state_t  state_r;
  logic [4:0]  candCode_r;
  logic [4:0]  tgtCode_r;
  logic [3:0]  qualCnt_r;
  logic [1:0]  stepCnt_r;
  logic [3:0]  ssCnt_r;
  logic [11:0] dacRef_r;
  logic [11:0] ssRef_r;
  logic        passed_r;
  logic        ovTrip_r;
  vrs_gate_t   gate_r;

  // ticks
  wire tenMode = (mode_r == VRS_MODE_TEN);
  logic swTick;
  logic sampleTick;
  vrs_tick_gen #(.SW_DIV(SW_DIV)) uTick (.sys_clk(sys_clk), .rst(rst), .tenMode(tenMode),
    .swTick(swTick), .sampleTick(sampleTick)); // [RULE1] [RULE4]

  // code qualification
  wire        codeNew   = sampleTick && (codeS != candCode_r);
  wire        qualInc   = tenMode ? (sampleTick && !codeNew) : swTick;
  wire [3:0]  qualGoal  = tenMode ? 4'(TEN_QUAL_READS) : 4'(QUAL_SW_CYCLES);
  wire        qualDone  = (qualCnt_r == qualGoal) && !codeNew; // [RULE2] [RULE5] [RULE8]
  wire        adopt     = qualDone && (candCode_r != tgtCode_r);
  wire [11:0] tgtRef    = codeToRef(mode_r, tgtCode_r); // [RULE21]
  wire [11:0] modeLsb   = (mode_r == VRS_MODE_TEN) ? TEN_LSB : (mode_r == VRS_MODE_ALT) ? ALT_LSB : LEGACY_LSB;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      candCode_r <= CODE_RESET;
      tgtCode_r  <= CODE_RESET;
      qualCnt_r  <= '0;
    end
    else
    begin
      if (codeNew)
      begin
        candCode_r <= codeS;
        qualCnt_r  <= tenMode ? 4'h1 : 4'h0; // [RULE5]
      end
      else if (qualInc && qualCnt_r != qualGoal)
        qualCnt_r <= qualCnt_r + 4'h1;
      if (adopt)
        tgtCode_r <= candCode_r;
    end
  end

  // reference stepping
  wire        refUp     = tgtRef > dacRef_r;
  wire [11:0] refDiff   = refUp ? 12'(tgtRef - dacRef_r) : 12'(dacRef_r - tgtRef);
  wire        stepDue   = swTick && (stepCnt_r == 2'(STEP_SW_CYCLES - 1));
  wire [11:0] refStep   = (refDiff <= modeLsb) ? tgtRef :
                          refUp ? 12'(dacRef_r + modeLsb) : 12'(dacRef_r - modeLsb); // [RULE20]

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dacRef_r  <= '0;
      stepCnt_r <= '0;
    end
    else if (state_r != VRS_ST_RUN || tenMode)
    begin
      dacRef_r  <= tgtRef; // [RULE6] [RULE7]
      stepCnt_r <= '0;
    end
    else if (dacRef_r == tgtRef)
      stepCnt_r <= '0;
    else if (swTick)
    begin
      stepCnt_r <= stepDue ? 2'h0 : stepCnt_r + 2'h1;
      if (stepDue)
        dacRef_r <= refStep; // [RULE3]
    end
  end

  // enable and soft-start
  wire        vccOk     = lvlS[1];
  wire        noLoad    = (codeS == NO_LOAD_CODE); // [RULE16]
  wire        enableAll = lvlS[2] && vccOk && lvlS[0] && !noLoad; // [RULE15]
  wire        ssLast    = swTick && (ssCnt_r == 4'(SS_STEP_SW_CYCLES - 1));
  wire [12:0] ssSum     = {1'b0, ssRef_r} + SS_STEP;
  wire [11:0] ssNext    = (ssSum >= {1'b0, dacRef_r}) ? dacRef_r : ssSum[11:0];

  always_ff @(posedge sys_clk)
  begin
    if (rst || !enableAll)
    begin
      state_r  <= VRS_ST_OFF;
      ssCnt_r  <= '0;
      ssRef_r  <= '0;
      passed_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        VRS_ST_OFF:
          state_r <= VRS_ST_WAIT; // [RULE17]
        VRS_ST_WAIT:
        begin
          if (swTick)
            ssCnt_r <= ssCnt_r + 4'h1;
          if (swTick && ssCnt_r == 4'(SS_WAIT_SW_CYCLES - 1))
            state_r <= VRS_ST_RAMP; // [RULE18]
        end
        VRS_ST_RAMP:
        begin
          if ({1'b0, ssRef_r} > {1'b0, fbS})
            passed_r <= 1'b1; // [RULE19]
          if (swTick)
            ssCnt_r <= ssCnt_r + 4'h1;
          if (ssLast)
            ssRef_r <= ssNext; // [RULE18]
          if (ssRef_r >= dacRef_r)
            state_r <= VRS_ST_RUN;
        end
        VRS_ST_RUN:
          passed_r <= 1'b1;
        default:
          state_r <= VRS_ST_OFF;
      endcase
    end
  end

  // overvoltage comparator
  wire [12:0] fixedThr  = (mode_r == VRS_MODE_LEGACY) ? OV_FIXED_HIGH : OV_FIXED_LOW; // [RULE9]
  wire [12:0] marginThr = {1'b0, dacRef_r} + OV_MARGIN;
  wire        inSs      = (state_r == VRS_ST_WAIT) || (state_r == VRS_ST_RAMP);
  wire [12:0] ovThr     = (state_r == VRS_ST_RUN) ? marginThr : // [RULE11]
                          inSs ? ((marginThr > fixedThr) ? marginThr : fixedThr) : fixedThr; // [RULE10]
  wire        ovAbove   = {1'b0, fbS} > ovThr;
  wire        ovRelease = {1'b0, fbS} < 13'(ovThr - OV_HYST);

  always_ff @(posedge sys_clk)
  begin
    if (rst || !vccOk)
      ovTrip_r <= 1'b0;
    else if (ovAbove)
      ovTrip_r <= 1'b1; // [RULE12]
    else if (ovRelease)
      ovTrip_r <= 1'b0; // [RULE12] [RULE13]
  end

  // gate drive
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      gate_r <= '0;
    else
    begin
      gate_r.lowOe    <= vccOk; // [RULE14]
      gate_r.lowForce <= vccOk && (ovTrip_r || ovAbove);
      gate_r.pwmEn    <= !ovTrip_r && !ovAbove &&
                         (state_r == VRS_ST_RUN || (state_r == VRS_ST_RAMP && passed_r)); // [RULE19] [RULE13]
    end
  end

  assign lowSideGate     = gate_r;
  assign overvoltageTrip = ovTrip_r;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      referenceOut    <= '0;
      softStartActive <= 1'b0;
    end
    else
    begin
      referenceOut    <= (state_r == VRS_ST_RUN) ? dacRef_r : ssRef_r;
      softStartActive <= inSs;
    end
  end

  // register port
  wire        wrCtrl   = busReq.wrEn && (busReq.addr == REG_CTRL);
  wire [1:0]  wrMode   = busReq.wdata[CTRL_MODE_LSB +: 2];
  wire [31:0] statWord = (32'(state_r) << STAT_STATE_LSB) | (32'(ovTrip_r) << STAT_OV_BIT) |
                         (32'(passed_r) << STAT_PASSED_BIT) | (32'(noLoad) << STAT_NOLOAD_BIT) |
                         (32'(tgtCode_r) << STAT_CODE_LSB);
  wire [31:0] refWord  = (32'(dacRef_r) << REF_DAC_LSB) | (32'(ssRef_r) << REF_SS_LSB);
  wire [31:0] rdMux    = (busReq.addr == REG_CTRL) ? (32'(mode_r) << CTRL_MODE_LSB) :
                         (busReq.addr == REG_STATUS) ? statWord :
                         (busReq.addr == REG_REF) ? refWord : 32'h0000_0000;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mode_r    <= MODE_RESET;
      busRdData <= '0;
    end
    else
    begin
      if (wrCtrl && wrMode != 2'b11)
        mode_r <= vrs_mode_t'(wrMode); // [RULE21]
      busRdData <= busReq.rdEn ? rdMux : 32'h0000_0000;
    end
  end

  // checks
  property p_ten_direct;
    @(posedge sys_clk) disable iff (rst)
      (tenMode && state_r == VRS_ST_RUN && adopt) |=> ##1 (dacRef_r == codeToRef(mode_r, $past(candCode_r, 2)));
  endproperty
  a_ten_direct: assert property (p_ten_direct) else $error("ten-series reference not set directly"); // [RULE6]

  property p_step_lsb;
    @(posedge sys_clk) disable iff (rst)
      (!tenMode && $past(!tenMode) && state_r == VRS_ST_RUN && $past(state_r) == VRS_ST_RUN && $changed(dacRef_r))
      |-> ((dacRef_r > $past(dacRef_r)) ? (dacRef_r - $past(dacRef_r)) : ($past(dacRef_r) - dacRef_r)) <= modeLsb;
  endproperty
  a_step_lsb: assert property (p_step_lsb) else $error("step larger than one lsb"); // [RULE20]

  property p_step_spacing;
    @(posedge sys_clk) disable iff (rst)
      (!tenMode && state_r == VRS_ST_RUN && $past(state_r) == VRS_ST_RUN && $changed(dacRef_r))
      |-> ($past(swTick) && $past(stepCnt_r) == 2'h3);
  endproperty
  a_step_spacing: assert property (p_step_spacing) else $error("step not on fourth cycle"); // [RULE3]

  property p_qual;
    @(posedge sys_clk) disable iff (rst)
      $changed(tgtCode_r) |-> $past(qualCnt_r) == (tenMode ? 4'h3 : 4'hC);
  endproperty
  a_qual: assert property (p_qual) else $error("code adopted before qualification"); // [RULE2] [RULE5]

  property p_disable;
    @(posedge sys_clk) disable iff (rst)
      (noLoad || !lvlS[2]) |=> (state_r == VRS_ST_OFF ##1 !gate_r.pwmEn);
  endproperty
  a_disable: assert property (p_disable) else $error("controller ran while disabled"); // [RULE15] [RULE16]

  property p_start;
    @(posedge sys_clk) disable iff (rst)
      (state_r == VRS_ST_OFF && enableAll) |=> (state_r == VRS_ST_WAIT);
  endproperty
  a_start: assert property (p_start) else $error("soft-start did not begin at once"); // [RULE17]

  property p_wait16;
    @(posedge sys_clk) disable iff (rst)
      ($past(state_r) == VRS_ST_WAIT && state_r == VRS_ST_RAMP) |-> ($past(ssCnt_r) == 4'hF && $past(swTick));
  endproperty
  a_wait16: assert property (p_wait16) else $error("ramp began before 16 cycles"); // [RULE18]

  property p_ov_trip;
    @(posedge sys_clk) disable iff (rst)
      (vccOk && ovAbove) |=> (ovTrip_r && gate_r.lowForce && !gate_r.pwmEn);
  endproperty
  a_ov_trip: assert property (p_ov_trip) else $error("overvoltage did not force low side"); // [RULE9] [RULE12]

  property p_ov_run_thr;
    @(posedge sys_clk) disable iff (rst)
      (state_r == VRS_ST_RUN) |-> (ovThr == {1'b0, dacRef_r} + OV_MARGIN);
  endproperty
  a_ov_run_thr: assert property (p_ov_run_thr) else $error("run threshold not reference plus margin"); // [RULE11]

  property p_tristate;
    @(posedge sys_clk) disable iff (rst)
      !vccOk |=> !gate_r.lowOe && !gate_r.lowForce;
  endproperty
  a_tristate: assert property (p_tristate) else $error("low drive active below bias"); // [RULE14]

  property p_prebias;
    @(posedge sys_clk) disable iff (rst)
      (state_r == VRS_ST_RAMP && !passed_r) |=> !gate_r.pwmEn;
  endproperty
  a_prebias: assert property (p_prebias) else $error("drives on above ramp"); // [RULE19]

  c_ov_trip:  cover property (@(posedge sys_clk) disable iff (rst) $rose(ovTrip_r) ##[1:1000] $fell(ovTrip_r));
  c_ten_move: cover property (@(posedge sys_clk) disable iff (rst) tenMode && state_r == VRS_ST_RUN && adopt);
  c_leg_step: cover property (@(posedge sys_clk) disable iff (rst) !tenMode && state_r == VRS_ST_RUN && stepDue);
  c_ss_done:  cover property (@(posedge sys_clk) disable iff (rst) state_r == VRS_ST_RAMP ##1 state_r == VRS_ST_RUN);
endmodule

// file: verilog/vrs_pkg.sv
// vrs_pkg: constants, types and code tables of the reference sequencer
// assumes one 200 MHz clock; reference words count in 0.5 mV units
package vrs_pkg;

  // clock and switching rate
  localparam int unsigned CLK_FREQ_KHZ      = 200000;
  localparam int unsigned SW_FREQ_KHZ       = 222;
  localparam int unsigned SW_DIV_CYCLES     = CLK_FREQ_KHZ / SW_FREQ_KHZ;

  // code sampling and qualification, counted in switching cycles or readings
  localparam int unsigned SAMPLES_LEGACY    = 4;
  localparam int unsigned SAMPLES_TEN       = 6;
  localparam int unsigned QUAL_SW_CYCLES    = 12;
  localparam int unsigned TEN_QUAL_READS    = 3;
  localparam int unsigned STEP_SW_CYCLES    = 4;
  localparam int unsigned SS_WAIT_SW_CYCLES = 16;
  localparam int unsigned SS_STEP_SW_CYCLES = 16;

  // reference scaling
  localparam int unsigned REF_W             = 12;
  localparam int unsigned REF_UNIT_UV       = 500;
  localparam int unsigned SS_STEP_UV        = 12500;
  localparam int unsigned OV_FIXED_LOW_MV   = 1650;
  localparam int unsigned OV_FIXED_HIGH_MV  = 1950;
  localparam int unsigned OV_MARGIN_MV      = 200;
  localparam int unsigned OV_HYST_MV        = 50;
  localparam logic [12:0] SS_STEP           = 13'(SS_STEP_UV / REF_UNIT_UV);
  localparam logic [12:0] OV_FIXED_LOW      = 13'(OV_FIXED_LOW_MV * 1000 / REF_UNIT_UV);
  localparam logic [12:0] OV_FIXED_HIGH     = 13'(OV_FIXED_HIGH_MV * 1000 / REF_UNIT_UV);
  localparam logic [12:0] OV_MARGIN         = 13'(OV_MARGIN_MV * 1000 / REF_UNIT_UV);
  localparam logic [12:0] OV_HYST           = 13'(OV_HYST_MV * 1000 / REF_UNIT_UV);

  // code tables: value = base - code * lsb
  localparam logic [11:0] LEGACY_BASE       = 12'(1850 * 1000 / REF_UNIT_UV);
  localparam logic [11:0] LEGACY_LSB        = 12'(25000 / REF_UNIT_UV);
  localparam logic [11:0] TEN_BASE          = 12'(1725000 / REF_UNIT_UV);
  localparam logic [11:0] TEN_LSB           = 12'(12500 / REF_UNIT_UV);
  localparam logic [11:0] ALT_BASE          = 12'(1550 * 1000 / REF_UNIT_UV);
  localparam logic [11:0] ALT_LSB           = 12'(25000 / REF_UNIT_UV);
  localparam logic [4:0]  NO_LOAD_CODE      = 5'h1F;
  localparam logic [4:0]  CODE_RESET        = 5'h1F;

  // register map
  localparam logic [3:0]  REG_CTRL          = 4'h0;
  localparam logic [3:0]  REG_STATUS        = 4'h4;
  localparam logic [3:0]  REG_REF           = 4'h8;
  localparam int unsigned CTRL_MODE_LSB     = 0;
  localparam int unsigned STAT_STATE_LSB    = 0;
  localparam int unsigned STAT_OV_BIT       = 2;
  localparam int unsigned STAT_PASSED_BIT   = 3;
  localparam int unsigned STAT_NOLOAD_BIT   = 4;
  localparam int unsigned STAT_CODE_LSB     = 8;
  localparam int unsigned REF_DAC_LSB       = 0;
  localparam int unsigned REF_SS_LSB        = 16;

  typedef enum logic [1:0] {
    VRS_MODE_LEGACY = 2'b00,
    VRS_MODE_TEN    = 2'b01,
    VRS_MODE_ALT    = 2'b10
  } vrs_mode_t;

  localparam vrs_mode_t MODE_RESET = VRS_MODE_LEGACY;

  typedef enum logic [1:0] {
    VRS_ST_OFF  = 2'b00,
    VRS_ST_WAIT = 2'b01,
    VRS_ST_RAMP = 2'b10,
    VRS_ST_RUN  = 2'b11
  } vrs_state_t;

  typedef struct packed {
    logic pwmEn;
    logic lowForce;
    logic lowOe;
  } vrs_gate_t;

  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } vrs_bus_req_t;

endpackage

// file: verilog/vrs_sync.sv
// vrs_sync: two-flop synchroniser for pin levels
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/10ps
module vrs_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  import vrs_pkg::*;

  logic [W-1:0] stage1_r;

  initial
  begin
    if (W < 1) $error("vrs_sync: W must be at least 1");
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stage1_r <= '0;
      syncOut  <= '0;
    end
    else
    begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end
endmodule

// file: verilog/vrs_tick_gen.sv
// vrs_tick_gen: switching-cycle tick and code sampling ticks
// assumes one sys_clk domain; tenMode picks six samples per cycle, else four
`timescale 1ns/10ps
module vrs_tick_gen #(
  parameter int unsigned SW_DIV = vrs_pkg::SW_DIV_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // mode
  input  wire logic tenMode,
  // ticks
  output logic      swTick,
  output logic      sampleTick
);
  import vrs_pkg::*;

  localparam logic [15:0] SW_LAST   = 16'(SW_DIV - 1);
  localparam logic [15:0] SUB_LEG   = 16'(SW_DIV / SAMPLES_LEGACY - 1);
  localparam logic [15:0] SUB_TEN   = 16'(SW_DIV / SAMPLES_TEN - 1);

  logic [15:0] swCnt_r;
  logic [15:0] subCnt_r;
  logic [2:0]  smpCnt_r;
  wire  [15:0] subLast = tenMode ? SUB_TEN : SUB_LEG;
  wire         subHit  = (subCnt_r == subLast);

  initial
  begin
    if (SW_DIV < 24 || SW_DIV > 65535) $error("vrs_tick_gen: SW_DIV out of range");
  end

  assign swTick     = (swCnt_r == SW_LAST);
  assign sampleTick = subHit && (smpCnt_r != (tenMode ? 3'(SAMPLES_TEN) : 3'(SAMPLES_LEGACY)));

  always_ff @(posedge sys_clk)
  begin
    if (rst || swTick)
    begin
      swCnt_r  <= '0;
      subCnt_r <= '0;
      smpCnt_r <= '0;
    end
    else
    begin
      swCnt_r  <= swCnt_r + 16'h0001;
      subCnt_r <= subHit ? 16'h0000 : subCnt_r + 16'h0001;
      smpCnt_r <= sampleTick ? smpCnt_r + 3'h1 : smpCnt_r;
    end
  end

  // sample count per switching cycle
  logic [2:0] seen_r;
  logic       tenPrev_r;
  always_ff @(posedge sys_clk)
  begin
    if (rst || swTick)
      seen_r <= '0;
    else if (sampleTick)
      seen_r <= seen_r + 3'h1;
    if (rst || swTick)
      tenPrev_r <= tenMode;
  end

  property p_ten_rate;
    @(posedge sys_clk) disable iff (rst)
      (swTick && tenMode && tenPrev_r && !$past(rst)) |-> ((seen_r + 3'(sampleTick)) == 3'h6);
  endproperty
  a_ten_rate: assert property (p_ten_rate) else $error("ten-series mode missed six samples"); // [RULE4]

  property p_leg_rate;
    @(posedge sys_clk) disable iff (rst)
      (swTick && !tenMode && !tenPrev_r && !$past(rst)) |-> ((seen_r + 3'(sampleTick)) == 3'h4);
  endproperty
  a_leg_rate: assert property (p_leg_rate) else $error("legacy mode missed four samples"); // [RULE1]
endmodule

// file: tb/vrs_cpu_model.sv
// vrs_cpu_model: processor side of the sequencer, drives the five code pins
// assumes sys_clk from the bench; every code change lands on a rising edge
`timescale 1ns/10ps
module vrs_cpu_model (
  // clock
  input  wire logic       sys_clk,
  // code pins
  output logic      [4:0] voltageCodeInputs
);
  initial voltageCodeInputs = 5'h1F;

  // set a code at once (non-ten modes, no-load code)
  task automatic jump(input logic [4:0] c);
    @(posedge sys_clk);
    voltageCodeInputs <= c;
  endtask

  // one code step at a time, gap cycles before each step
  task automatic walk(input logic [4:0] c, input int gap);
    while (voltageCodeInputs !== c)
    begin
      repeat (gap) @(posedge sys_clk);
      voltageCodeInputs <= voltageCodeInputs + ((voltageCodeInputs < c) ? 5'h01 : 5'h1F);
      @(negedge sys_clk);
    end
  endtask
endmodule

// file: tb/testbench.sv
// testbench: start-up, code tracking, overvoltage and no-load of vrs_sequencer
// assumes SW_DIV of 24 and the processor model on the code pins
`timescale 1ns/10ps
module testbench;
  import vrs_pkg::*;
  localparam int SWD = 24;
  logic         sys_clk;
  logic         rst;
  vrs_bus_req_t busReq;
  logic [31:0]  busRdData;
  logic [4:0]   voltageCodeInputs;
  logic         thresholdEnableInput;
  logic         coreBiasOk;
  logic         driverBiasSupplyOk;
  logic [11:0]  feedbackSense;
  vrs_gate_t    lowSideGate;
  logic [11:0]  referenceOut;
  logic         overvoltageTrip;
  logic         softStartActive;
  logic [31:0]  rdv;
  int           n;
  int           num_errors;
  int           checks_done;

  vrs_sequencer #(.SW_DIV(SWD)) vrs_sequencer_inst (.sys_clk(sys_clk), .rst(rst), .busReq(busReq),
    .busRdData(busRdData), .voltageCodeInputs(voltageCodeInputs),
    .thresholdEnableInput(thresholdEnableInput), .coreBiasOk(coreBiasOk),
    .driverBiasSupplyOk(driverBiasSupplyOk), .feedbackSense(feedbackSense), .lowSideGate(lowSideGate),
    .referenceOut(referenceOut), .overvoltageTrip(overvoltageTrip), .softStartActive(softStartActive));
  vrs_cpu_model vrs_cpu_model_inst (.sys_clk(sys_clk), .voltageCodeInputs(voltageCodeInputs));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lv(input logic [4:0] c);
    return 32'(LEGACY_BASE - 12'(c) * LEGACY_LSB);
  endfunction

  function automatic logic [31:0] tv(input logic [4:0] c);
    return 32'(TEN_BASE - 12'(c) * TEN_LSB);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    busReq <= {1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    busReq <= '0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    busReq <= {1'b0, 1'b1, a, 32'h0};
    @(posedge sys_clk);
    busReq <= '0;
    #1;
    rdv = busRdData;
  endtask

  task automatic fb(input logic [11:0] v, input int k);
    @(posedge sys_clk);
    feedbackSense <= v;
    cyc(k);
    #1;
  endtask

  task automatic wait_change(input int maxc);
    logic [11:0] old;
    old = referenceOut;
    for (int i = 0; i < maxc; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (referenceOut !== old)
        break;
    end
  endtask

  task automatic test_end(input string t);
    $display("test %s done, errors %0d", t, num_errors);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    num_errors = 0;
    checks_done = 0;
    rst = 1'b1;
    busReq = '0;
    thresholdEnableInput = 1'b0;
    coreBiasOk = 1'b0;
    driverBiasSupplyOk = 1'b0;
    feedbackSense = 12'd1000;
    cyc(16);
    rst <= 1'b0;
    rd(REG_CTRL);
    chk("ctrl reset", 32'h0, rdv);
    wr(REG_CTRL, 32'h3);
    rd(REG_CTRL);
    chk("ctrl mode3", 32'h0, rdv);
    rd(4'hC);
    chk("unmapped", 32'h0, rdv);
    chk("oe no bias", 1'b0, lowSideGate.lowOe);
    test_end("registers");
    @(posedge sys_clk);
    coreBiasOk <= 1'b1;
    driverBiasSupplyOk <= 1'b1;
    vrs_cpu_model_inst.jump(5'h1E);
    cyc(8);
    #1;
    chk("no enable", 1'b0, softStartActive);
    chk("oe bias", 1'b1, lowSideGate.lowOe);
    @(posedge sys_clk);
    thresholdEnableInput <= 1'b1;
    cyc(4);
    #1;
    chk("start", 1'b1, softStartActive);
    fb(12'd3900, 6);
    chk("ss ov fixed", 1'b0, overvoltageTrip);
    fb(12'd3901, 4);
    chk("ss ov trip", 1'b1, overvoltageTrip);
    fb(12'd1000, 5);
    cyc(15 * SWD - 40);
    rd(REG_STATUS);
    chk("wait state", 32'(VRS_ST_WAIT), 32'(rdv[1:0]));
    cyc(2 * SWD + 8);
    rd(REG_STATUS);
    chk("ramp state", 32'(VRS_ST_RAMP), 32'(rdv[1:0]));
    chk("fb above ramp", 1'b0, lowSideGate.pwmEn);
    for (n = 0; n < 20000 && lowSideGate.pwmEn !== 1'b1; n++)
    begin
      @(posedge sys_clk);
      #1;
    end
    rd(REG_REF);
    chk("ramp over fb", 32'(1000 + SS_STEP), 32'(rdv[27:16]));
    for (n = 0; n < 25000 && softStartActive !== 1'b0; n++)
    begin
      @(posedge sys_clk);
      #1;
    end
    cyc(2);
    #1;
    chk("run ref", lv(5'h1E), 32'(referenceOut));
    chk("run pwm", 1'b1, lowSideGate.pwmEn);
    test_end("startup");
    vrs_cpu_model_inst.jump(5'h1C);
    cyc(10 * SWD);
    #1;
    chk("qual hold", lv(5'h1E), 32'(referenceOut));
    wait_change(9 * SWD);
    chk("step 1", lv(5'h1D), 32'(referenceOut));
    cyc(3 * SWD);
    #1;
    chk("step hold", lv(5'h1D), 32'(referenceOut));
    wait_change(2 * SWD);
    chk("step 2", lv(5'h1C), 32'(referenceOut));
    test_end("legacy");
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL);
    chk("ctrl ten", 32'h1, rdv);
    cyc(2 * SWD);
    #1;
    chk("ten table", tv(5'h1C), 32'(referenceOut));
    vrs_cpu_model_inst.walk(5'h1B, SWD);
    wait_change(SWD);
    chk("ten direct", tv(5'h1B), 32'(referenceOut));
    test_end("ten");
    fb(12'd3175, 6);
    chk("ov at thr", 1'b0, overvoltageTrip);
    fb(12'd3176, 4);
    chk("ov trip", 32'h2, 32'({lowSideGate.lowForce, lowSideGate.pwmEn}));
    fb(12'd3076, 6);
    chk("ov hold", 1'b1, overvoltageTrip);
    fb(12'd3074, 4);
    chk("ov clear", 32'h1, 32'({lowSideGate.lowForce, lowSideGate.pwmEn}));
    fb(12'd3176, 4);
    chk("ov again", 1'b1, overvoltageTrip);
    fb(12'd1000, 4);
    rd(REG_STATUS);
    chk("run kept", 32'(VRS_ST_RUN), 32'(rdv[1:0]));
    test_end("overvoltage");
    vrs_cpu_model_inst.jump(NO_LOAD_CODE);
    cyc(5);
    #1;
    chk("noload off", 32'h0, 32'({softStartActive, lowSideGate.pwmEn}));
    fb(12'd3300, 6);
    chk("fixed thr", 1'b0, overvoltageTrip);
    fb(12'd3301, 4);
    chk("fixed trip", 1'b1, overvoltageTrip);
    fb(12'd1000, 4);
    vrs_cpu_model_inst.jump(5'h1E);
    cyc(5);
    #1;
    chk("restart", 1'b1, softStartActive);
    @(posedge sys_clk);
    coreBiasOk <= 1'b0;
    cyc(4);
    #1;
    chk("bias lost", 32'h0, 32'({lowSideGate.lowOe, lowSideGate.pwmEn}));
    test_end("noload");
    print_verdict;
  end

  initial
  begin
    cyc(60000);
    num_errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    print_verdict;
  end
endmodule
